// ==== src/pmb_top.sv ====
`timescale 1ns/10ps
module pmb_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu side pins
    input wire logic [15:0] cpu_address,
    input wire logic address_strobe_input_n,
    input wire logic operand_instruction_select,
    input wire logic cpu_read_write_n,
    input wire logic cpu_privileged,
    // memory side pins
    output logic [pmb_pkg::PMB_EA_W-1:0] extended_address_bus,
    output logic extended_address_strobe,
    output logic memory_protect_fault_n,
    output logic protect_check_valid_n,
    output logic [3:0] address_state_bits,
    output logic [3:0] processor_key
);
    import pmb_pkg::*;

    typedef enum logic [5:0] {
        PMB_IDLE = 6'b000001,
        PMB_LOAD = 6'b000010,
        PMB_XLATE = 6'b000100,
        PMB_CHECK = 6'b001000,
        PMB_PASS = 6'b010000,
        PMB_FAIL = 6'b100000
    } pmb_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic lock_ok(input logic [3:0] lock, input logic [3:0] key);
        lock_ok = (key == PMB_KEY_MASTER) || (lock == PMB_LOCK_OPEN) ||
                  (lock != PMB_LOCK_MASTER && key == lock);
    endfunction

    function automatic logic [PMB_PPN_W-1:0] ent_ppn(input logic [PMB_ENTRY_W-1:0] e);
        ent_ppn = e[PMB_ENT_PPN_LSB +: PMB_PPN_W];
    endfunction

    function automatic logic [3:0] ent_lock(input logic [PMB_ENTRY_W-1:0] e);
        ent_lock = e[PMB_ENT_LOCK_LSB +: PMB_LOCK_W];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    logic [1:0] rst_pipe_q;
    logic rst_sync_n;
    logic [19:0] pin_s1_q;
    logic [19:0] pin_s2_q;
    logic [19:0] pin_raw;
    logic [15:0] addr_s;
    logic as_n_s;
    logic oin_s;
    logic rw_n_s;
    logic priv_s;
    logic as_n_prev_q;
    logic as_fall;
    logic as_rise;

    // reset asserts asynchronously, released through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'b00;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_q[1];

    assign pin_raw = {cpu_privileged, cpu_read_write_n, operand_instruction_select,
                      address_strobe_input_n, cpu_address};

    // two-flop synchroniser for all cpu pins; strobe idles high
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_s1_q <= 20'h10000;
            pin_s2_q <= 20'h10000;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end
    assign addr_s = pin_s2_q[15:0];
    assign as_n_s = pin_s2_q[16];
    assign oin_s = pin_s2_q[17];
    assign rw_n_s = pin_s2_q[18];
    assign priv_s = pin_s2_q[19];

    // strobe edge detection on the settled copy
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            as_n_prev_q <= 1'b1;
        end else begin
            as_n_prev_q <= as_n_s;
        end
    end
    assign as_fall = as_n_prev_q && !as_n_s;
    assign as_rise = !as_n_prev_q && as_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // software-visible registers

    logic [3:0] config_q;
    logic [7:0] shadow_q;
    logic [15:0] xdata_q;
    logic xerr_q;
    logic fault_seen_q;
    logic apb_wr;
    logic apb_setup;
    logic mmu_on;
    logic bpu_on;
    logic mode_b;
    logic map_hit;
    logic clear_done;

    assign apb_wr = psel && penable && pwrite;
    assign apb_setup = psel && !penable;
    assign map_hit = (paddr == PMB_A_CONFIG) || (paddr == PMB_A_SHADOW) || (paddr == PMB_A_XDATA) ||
                     (paddr == PMB_A_XCMD) || (paddr == PMB_A_STATUS);
    assign mmu_on = config_q[PMB_CFG_MMU];
    assign bpu_on = config_q[PMB_CFG_BPU];
    assign mode_b = config_q[PMB_CFG_MODEB];

    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !map_hit;

    // configuration captured when software writes the configuration word
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            config_q <= 4'h0;
        end else if (apb_wr && paddr == PMB_A_CONFIG) begin
            config_q <= pwdata[3:0];
        end
    end

    // status word shadow follows every software write to the shadow address
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            shadow_q <= 8'h00;
        end else if (apb_wr && paddr == PMB_A_SHADOW) begin
            shadow_q <= pwdata[7:0];
        end
    end
    assign address_state_bits = shadow_q[3:0];
    assign processor_key = shadow_q[7:4];

    ////////////////////////////////////////////////////////////////////////////
    // command trap

    logic xcmd_go;
    logic [7:0] xop;
    logic xin_range;
    logic xallowed;
    logic pt_wr;
    logic pw_wr;
    logic [PMB_IDX_W-1:0] pt_xidx;
    logic [PMB_ENTRY_W-1:0] pt_xdata;
    logic [PMB_PW_W-1:0] pw_word;

    assign xcmd_go = apb_wr && paddr == PMB_A_XCMD;
    assign xop = pwdata[15:8];
    assign xin_range = (xop >= PMB_X_PW_WR) && (xop <= PMB_X_PO_RD);
    assign xallowed = xcmd_go && xin_range && priv_s;
    // low byte is set in the upper nibble and page in the lower
    assign pt_xidx = {(xop == PMB_X_PO_WR || xop == PMB_X_PO_RD), pwdata[7:0]};
    assign pt_wr = xallowed && (xop == PMB_X_PI_WR || xop == PMB_X_PO_WR);
    assign pw_wr = xallowed && xop == PMB_X_PW_WR;

    // data register is loaded by software or by a read command
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            xdata_q <= 16'h0000;
        end else if (xallowed && (xop == PMB_X_PI_RD || xop == PMB_X_PO_RD)) begin
            xdata_q <= pt_xdata;
        end else if (xallowed && xop == PMB_X_PW_RD) begin
            xdata_q <= pw_word;
        end else if (apb_wr && paddr == PMB_A_XDATA) begin
            xdata_q <= pwdata[15:0];
        end
    end

    // sticky refusal flag; a new refusal wins over a write-one clear
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            xerr_q <= 1'b0;
        end else if (xcmd_go && !(xin_range && priv_s)) begin
            xerr_q <= 1'b1;
        end else if (apb_wr && paddr == PMB_A_STATUS && pwdata[PMB_ST_XERR]) begin
            xerr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // table storage

    logic [PMB_IDX_W-1:0] xl_idx;
    logic [PMB_ENTRY_W-1:0] xl_entry;
    logic [PMB_EA_W-1:0] phys_q;
    logic [PMB_PW_IDX_W-1:0] pw_idx;
    logic [3:0] blk_sel;

    // set from address state bits, group from select, page from top address bits
    assign xl_idx = {oin_s, shadow_q[3:0], addr_s[15:12]};

    pmb_page_table #(
        .ENTRIES(1 << PMB_IDX_W)
    ) u_pages (
        .clock(clock),
        .rst_n(rst_sync_n),
        .wr_en(pt_wr),
        .wr_idx(pt_xidx),
        .wr_data(xdata_q),
        .rd_idx_a(xl_idx),
        .rd_data_a(xl_entry),
        .rd_idx_b(pt_xidx),
        .rd_data_b(pt_xdata)
    );

    // each word covers 16 blocks of 1K
    assign pw_idx = phys_q[19:14];
    assign blk_sel = phys_q[13:10];

    pmb_protect_ram #(
        .WORDS(1 << PMB_PW_IDX_W)
    ) u_protect (
        .clock(clock),
        .rst_n(rst_sync_n),
        .strobe_pulse(as_fall),
        .clear_done(clear_done),
        .wr_en(pw_wr),
        .wr_idx(pwdata[5:0]),
        .wr_data(xdata_q),
        .rd_idx(pw_idx),
        .rd_data(pw_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // translation caches, one for operands and one for instructions

    logic [1:0] cvalid_q;
    logic [7:0] ctag_q [2];
    logic [PMB_ENTRY_W-1:0] cent_q [2];
    logic chit;
    logic [PMB_ENTRY_W-1:0] cur_ent;
    pmb_state_e state_q;

    assign chit = cvalid_q[oin_s] && ctag_q[oin_s] == xl_idx[7:0];
    assign cur_ent = cent_q[oin_s];

    // reload on a page change; table writes drop both copies to stay coherent
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cvalid_q <= 2'b00;
            ctag_q[0] <= 8'h00;
            ctag_q[1] <= 8'h00;
            cent_q[0] <= '0;
            cent_q[1] <= '0;
        end else if (pt_wr) begin
            cvalid_q <= 2'b00;
        end else if (state_q == PMB_LOAD) begin
            cvalid_q[oin_s] <= 1'b1;
            ctag_q[oin_s] <= xl_idx[7:0];
            cent_q[oin_s] <= xl_entry;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access sequencer

    logic key_ok;
    logic dis_hit;
    logic mmu_bad;
    logic blk_bad;
    logic [PMB_EA_W-1:0] xl_phys;

    assign key_ok = lock_ok(ent_lock(cur_ent), shadow_q[7:4]);
    // operand write or instruction fetch of a disabled page
    assign dis_hit = cur_ent[PMB_ENT_DIS_BIT] && (oin_s ? !rw_n_s : rw_n_s);
    assign mmu_bad = !key_ok || dis_hit;
    // mode A drops the three upper page bits
    assign xl_phys = mode_b ? {ent_ppn(cur_ent), addr_s[PMB_OFS_W-1:0]}
                            : {3'h0, cur_ent[PMB_ENT_PPN_LSB +: PMB_EA_A_W-PMB_OFS_W], addr_s[PMB_OFS_W-1:0]};
    // reversed bit order: the lowest block sits in the top bit
    assign blk_bad = !rw_n_s && pw_word[PMB_PW_W-1-int'(blk_sel)];

    // strobe rising always ends the access, whatever the stage
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= PMB_IDLE;
        end else if (as_rise) begin
            state_q <= PMB_IDLE;
        end else begin
            unique case (state_q)
                PMB_IDLE: begin
                    if (as_fall) begin
                        if (mmu_on) begin
                            state_q <= chit ? PMB_XLATE : PMB_LOAD;
                        end else begin
                            state_q <= bpu_on ? PMB_CHECK : PMB_PASS;
                        end
                    end
                end
                PMB_LOAD: state_q <= PMB_XLATE;
                PMB_XLATE: begin
                    if (mmu_bad) begin
                        state_q <= PMB_FAIL;
                    end else begin
                        state_q <= bpu_on ? PMB_CHECK : PMB_PASS;
                    end
                end
                PMB_CHECK: state_q <= blk_bad ? PMB_FAIL : PMB_PASS;
                PMB_PASS: state_q <= PMB_PASS;
                PMB_FAIL: state_q <= PMB_FAIL;
            endcase
        end
    end

    // physical address: translated, or straight from the cpu bus
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            phys_q <= '0;
        end else if (state_q == PMB_XLATE && !mmu_bad) begin
            phys_q <= xl_phys;
        end else if (state_q == PMB_IDLE && as_fall && !mmu_on) begin
            phys_q <= {7'h00, addr_s};
        end
    end
    assign extended_address_bus = phys_q;

    // extended strobe rises once translation is accepted
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            extended_address_strobe <= 1'b0;
        end else if (as_rise || state_q == PMB_IDLE) begin
            extended_address_strobe <= 1'b0;
        end else if (state_q == PMB_XLATE && !mmu_bad) begin
            extended_address_strobe <= 1'b1;
        end
    end

    // protect output only rises on a passed access with strobe still low
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            memory_protect_fault_n <= 1'b0;
        end else begin
            memory_protect_fault_n <= !as_n_s && !as_rise && state_q == PMB_PASS;
        end
    end

    // valid falls after the block result settles; stays high without block unit
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            protect_check_valid_n <= 1'b1;
        end else begin
            protect_check_valid_n <= !(bpu_on && !as_n_s && !as_rise && (state_q == PMB_PASS ||
                                       (state_q == PMB_FAIL && (extended_address_strobe || !mmu_on))));
        end
    end

    // sticky record of a refused access; set wins over clear
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fault_seen_q <= 1'b0;
        end else if (state_q == PMB_FAIL) begin
            fault_seen_q <= 1'b1;
        end else if (apb_wr && paddr == PMB_A_STATUS && pwdata[PMB_ST_FAULT]) begin
            fault_seen_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, latched in the setup cycle so the access phase needs no wait

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata <= 32'h00000000;
        end else if (apb_setup && !pwrite) begin
            unique case (paddr)
                PMB_A_CONFIG: prdata <= {28'h0000000, config_q};
                PMB_A_SHADOW: prdata <= {24'h000000, shadow_q};
                PMB_A_XDATA: prdata <= {16'h0000, xdata_q};
                PMB_A_STATUS: prdata <= {26'h0000000, state_q[5:3], fault_seen_q, clear_done, xerr_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule // pmb_top

// ==== include/pmb_pkg.sv ====
package pmb_pkg;
    // geometry
    localparam int PMB_OFS_W = 12;
    localparam int PMB_PPN_W = 11;
    localparam int PMB_LOCK_W = 4;
    localparam int PMB_ENTRY_W = 16;
    localparam int PMB_IDX_W = 9;
    localparam int PMB_EA_W = 23;
    localparam int PMB_EA_A_W = 20;
    localparam int PMB_PW_W = 16;
    localparam int PMB_PW_IDX_W = 6;
    localparam int PMB_CLEAR_CYCLES = 256;
    // page entry layout
    localparam int PMB_ENT_PPN_LSB = 5;
    localparam int PMB_ENT_LOCK_LSB = 1;
    localparam int PMB_ENT_DIS_BIT = 0;
    localparam logic [3:0] PMB_LOCK_OPEN = 4'hF;
    localparam logic [3:0] PMB_KEY_MASTER = 4'h0;
    localparam logic [3:0] PMB_LOCK_MASTER = 4'h0;
    // apb map
    localparam logic [7:0] PMB_A_CONFIG = 8'h00;
    localparam logic [7:0] PMB_A_SHADOW = 8'h04;
    localparam logic [7:0] PMB_A_XDATA = 8'h08;
    localparam logic [7:0] PMB_A_XCMD = 8'h0C;
    localparam logic [7:0] PMB_A_STATUS = 8'h10;
    // config bits
    localparam int PMB_CFG_MMU = 0;
    localparam int PMB_CFG_BPU = 1;
    localparam int PMB_CFG_PAR = 2;
    localparam int PMB_CFG_MODEB = 3;
    // status bits
    localparam int PMB_ST_XERR = 0;
    localparam int PMB_ST_CLRDONE = 1;
    localparam int PMB_ST_FAULT = 2;
    // command codes (high byte)
    localparam logic [7:0] PMB_X_PW_WR = 8'h4D;
    localparam logic [7:0] PMB_X_PW_RD = 8'h4E;
    localparam logic [7:0] PMB_X_PI_WR = 8'h4F;
    localparam logic [7:0] PMB_X_PI_RD = 8'h50;
    localparam logic [7:0] PMB_X_PO_WR = 8'h51;
    localparam logic [7:0] PMB_X_PO_RD = 8'h52;
endpackage

// ==== src/pmb_page_table.sv ====
`timescale 1ns/10ps
module pmb_page_table #(
    parameter int ENTRIES = 512
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // write port
    input wire logic wr_en,
    input wire logic [pmb_pkg::PMB_IDX_W-1:0] wr_idx,
    input wire logic [pmb_pkg::PMB_ENTRY_W-1:0] wr_data,
    // read ports
    input wire logic [pmb_pkg::PMB_IDX_W-1:0] rd_idx_a,
    output logic [pmb_pkg::PMB_ENTRY_W-1:0] rd_data_a,
    input wire logic [pmb_pkg::PMB_IDX_W-1:0] rd_idx_b,
    output logic [pmb_pkg::PMB_ENTRY_W-1:0] rd_data_b
);
    import pmb_pkg::*;

    initial begin
        if (ENTRIES != (1 << PMB_IDX_W)) $error("page table depth must match index width");
    end

    logic [PMB_ENTRY_W-1:0] mem_q [ENTRIES];

    // one entry per index; low 8 index bits equal the logical page, so reset is identity
    for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
        localparam logic [PMB_IDX_W-1:0] IDX = PMB_IDX_W'(i);
        localparam logic [PMB_ENTRY_W-1:0] RST = {3'h0, IDX[7:0], PMB_LOCK_OPEN, 1'b0};
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                mem_q[i] <= RST;
            end else if (wr_en && wr_idx == IDX) begin
                mem_q[i] <= wr_data;
            end
        end
    end

    assign rd_data_a = mem_q[rd_idx_a];
    assign rd_data_b = mem_q[rd_idx_b];
endmodule // pmb_page_table

// ==== src/pmb_protect_ram.sv ====
`timescale 1ns/10ps
module pmb_protect_ram #(
    parameter int WORDS = 64
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // strobe pulse that paces the clear
    input wire logic strobe_pulse,
    output logic clear_done,
    // access
    input wire logic wr_en,
    input wire logic [pmb_pkg::PMB_PW_IDX_W-1:0] wr_idx,
    input wire logic [pmb_pkg::PMB_PW_W-1:0] wr_data,
    input wire logic [pmb_pkg::PMB_PW_IDX_W-1:0] rd_idx,
    output logic [pmb_pkg::PMB_PW_W-1:0] rd_data
);
    import pmb_pkg::*;

    initial begin
        if (WORDS != (1 << PMB_PW_IDX_W)) $error("protect memory depth must match index width");
    end

    logic [PMB_PW_W-1:0] mem_q [WORDS];
    logic [8:0] cnt_q;
    logic [PMB_PW_IDX_W-1:0] clr_idx;

    assign clear_done = (cnt_q == 9'(PMB_CLEAR_CYCLES));
    // four strobes per word so the whole sweep spans the documented count
    assign clr_idx = cnt_q[PMB_PW_IDX_W+1:2];

    // clear sweep counted in strobe pulses
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 9'h000;
        end else if (!clear_done && strobe_pulse) begin
            cnt_q <= cnt_q + 9'h001;
        end
    end

    // word storage; clearing has priority over software until done
    always_ff @(posedge clock) begin
        if (!clear_done) begin
            mem_q[clr_idx] <= '0;
        end else if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    // unswept words read as unprotected
    assign rd_data = clear_done ? mem_q[rd_idx] : '0;
endmodule // pmb_protect_ram

// ==== sim/pmb_top_chk.sv ====
`timescale 1ns/10ps
module pmb_top_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // cpu and memory pins
    input wire logic [15:0] cpu_address,
    input wire logic address_strobe_input_n,
    input wire logic [pmb_pkg::PMB_EA_W-1:0] extended_address_bus,
    input wire logic extended_address_strobe,
    input wire logic memory_protect_fault_n,
    input wire logic protect_check_valid_n,
    input wire logic [3:0] address_state_bits,
    input wire logic [3:0] processor_key
);
    import pmb_pkg::*;
    logic wr;
    logic [3:0] cfg_q;
    logic [7:0] sh_q;
    // shadow copies of config and status word, since the checker has no view inside
    assign wr = psel && penable && pwrite;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= 4'h0;
            sh_q <= 8'h00;
        end else begin
            if (wr && paddr == PMB_A_CONFIG) cfg_q <= pwdata[3:0];
            if (wr && paddr == PMB_A_SHADOW) sh_q <= pwdata[7:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // strobe held high long enough that every result has been withdrawn
    sequence s_idle; address_strobe_input_n [*6]; endsequence
    sequence s_xlate; $rose(extended_address_strobe); endsequence
    property p_rise; $rose(memory_protect_fault_n) |->
        !address_strobe_input_n && !$past(address_strobe_input_n, 3); endproperty
    a_rise: assert property (p_rise) else $error("protect output rose outside an access");
    property p_release; $rose(address_strobe_input_n) |-> ##[1:5] !memory_protect_fault_n; endproperty
    a_release: assert property (p_release) else $error("protect output not withdrawn");
    property p_idle; s_idle |-> protect_check_valid_n; endproperty
    a_idle: assert property (p_idle) else $error("check valid low between accesses");
    property p_nobpu; !cfg_q[PMB_CFG_BPU] |-> protect_check_valid_n; endproperty
    a_nobpu: assert property (p_nobpu) else $error("check valid low without block unit");
    property p_modea; s_xlate ##0 !cfg_q[PMB_CFG_MODEB] |-> extended_address_bus[22:20] == 3'h0; endproperty
    a_modea: assert property (p_modea) else $error("mode A address wider than 20 bits");
    property p_ofs; s_xlate |-> extended_address_bus[11:0] == cpu_address[11:0]; endproperty
    a_ofs: assert property (p_ofs) else $error("page offset altered");
    property p_xl; $fell(protect_check_valid_n) && cfg_q[PMB_CFG_MMU] |-> extended_address_strobe; endproperty
    a_xl: assert property (p_xl) else $error("block check before translation");
    property p_shadow; wr && paddr == PMB_A_SHADOW |->
        ##[1:2] {processor_key, address_state_bits} == sh_q; endproperty
    a_shadow: assert property (p_shadow) else $error("status shadow not reflected");
endmodule // pmb_top_chk
bind pmb_top pmb_top_chk u_chk (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cpu_address(cpu_address),
    .address_strobe_input_n(address_strobe_input_n), .extended_address_bus(extended_address_bus),
    .extended_address_strobe(extended_address_strobe), .memory_protect_fault_n(memory_protect_fault_n),
    .protect_check_valid_n(protect_check_valid_n), .address_state_bits(address_state_bits),
    .processor_key(processor_key));

// ==== sim/pmb_cpu_model.sv ====
`timescale 1ns/10ps
module pmb_cpu_model (
    // clock and answers
    input wire logic clock,
    input wire logic fault_n,
    input wire logic [pmb_pkg::PMB_EA_W-1:0] ea,
    // cpu pins
    output logic [15:0] addr,
    output logic as_n,
    output logic oi,
    output logic rw_n,
    output logic priv
);
    initial begin
        {addr, as_n, oi, rw_n, priv} = 20'h0000F;
    end
    // privilege level seen by command trapping
    task mode(input logic p);
        priv <= p;
    endtask
    // one access; a fault shows as the bus timeout of 14 clocks
    task acc(input logic [15:0] a, input logic o, w, output logic ok, output logic [22:0] e);
        addr <= a;
        oi <= o;
        rw_n <= !w;
        as_n <= 1'b0;
        for (int i = 0; i < 14 && fault_n !== 1'b1; i++) @(posedge clock);
        ok = fault_n;
        e = ea;
        as_n <= 1'b1;
        addr <= ~a; // released bus no longer shows the old address
        repeat (4) @(posedge clock);
    endtask
endmodule // pmb_cpu_model

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb;
    import pmb_pkg::*;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, err, ok, fn, vn, asn, ois, rwn, prv;
    logic [15:0] ca, a;
    logic [22:0] ea, e;
    logic [3:0] asb, pk, s, k;
    logic [10:0] ppn;
    integer seed = 32'h74a7, n_fail = 0, check_count = 0, i;
    pmb_top dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_address(ca), .address_strobe_input_n(asn), .operand_instruction_select(ois),
        .cpu_read_write_n(rwn), .cpu_privileged(prv), .extended_address_bus(ea),
        .extended_address_strobe(), .memory_protect_fault_n(fn), .protect_check_valid_n(vn),
        .address_state_bits(asb), .processor_key(pk));
    pmb_cpu_model cpu (.clock(clock), .fault_n(fn), .ea(ea), .addr(ca), .as_n(asn), .oi(ois),
        .rw_n(rwn), .priv(prv));
    initial forever #10 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one apb transfer; idle edge after it so psel never toggles twice in a step
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task xc(input logic [7:0] op, ix, input logic [15:0] d);
        apb(1'b1, PMB_A_XDATA, {16'h0, d});
        apb(1'b1, PMB_A_XCMD, {16'h0, op, ix});
    endtask
    function logic key_ok(input logic [3:0] l, kk);
        return l == PMB_LOCK_OPEN || kk == PMB_KEY_MASTER || kk == l;
    endfunction
    // watchdog, far beyond the few thousand cycles the sequence needs
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk("fault_n", fn, 1'b0);
        chk("valid_n", vn, 1'b1);
        for (i = 0; i < 256; i++) begin
            if (i == 255) begin
                apb(1'b0, PMB_A_STATUS, 32'h0);
                chk("clear early", r[PMB_ST_CLRDONE], 1'b0);
            end
            a = $random(seed);
            cpu.acc(a, 1'b1, 1'b1, ok, e);
            chk("no unit", ok, 1'b1);
        end
        apb(1'b0, PMB_A_STATUS, 32'h0);
        chk("clear done", r[PMB_ST_CLRDONE], 1'b1);
        apb(1'b1, PMB_A_CONFIG, 32'h1);
        apb(1'b0, PMB_A_CONFIG, 32'h0);
        chk("config", r[3:0], 4'h1);
        // identity map across random sets, keys and groups
        for (i = 0; i < 8; i++) begin
            {a, k, s} = $random(seed);
            apb(1'b1, PMB_A_SHADOW, {24'h0, k, s});
            cpu.acc(a, i[0], i[1], ok, e);
            chk("identity", e, {3'h0, s, a});
        end
        // mode B, every lock against corner and random keys
        apb(1'b1, PMB_A_CONFIG, 32'h9);
        for (i = 0; i < 16; i++) begin
            ppn = $random(seed);
            k = i[0] ? i[3:0] : (i[1] ? 4'h0 : $random(seed));
            xc(PMB_X_PO_WR, {s, a[15:12]}, {ppn, i[3:0], 1'b0});
            apb(1'b1, PMB_A_SHADOW, {24'h0, k, s});
            cpu.acc(a, 1'b1, 1'b0, ok, e);
            chk("key", ok, key_ok(i[3:0], k));
            if (ok === 1'b1) chk("mode B", e, {ppn, a[11:0]});
            cpu.acc(a, 1'b0, 1'b0, ok, e);
            chk("instr group", e, {3'h0, s, a});
        end
        xc(PMB_X_PO_WR, {s, a[15:12]}, {ppn, 4'hF, 1'b1});
        cpu.acc(a, 1'b1, 1'b1, ok, e);
        chk("op write dis", ok, 1'b0);
        cpu.acc(a, 1'b1, 1'b0, ok, e);
        chk("op read dis", ok, 1'b1);
        xc(PMB_X_PI_WR, {s, a[15:12]}, {ppn, 4'hF, 1'b1});
        cpu.acc(a, 1'b0, 1'b0, ok, e);
        chk("fetch dis", ok, 1'b0);
        // refused commands leave the table untouched
        cpu.mode(1'b0);
        xc(PMB_X_PO_WR, {s, a[15:12]}, 16'h1234);
        apb(1'b0, PMB_A_STATUS, 32'h0);
        chk("unpriv", r[PMB_ST_XERR], 1'b1);
        cpu.mode(1'b1);
        xc(PMB_X_PO_RD, {s, a[15:12]}, 16'h0);
        apb(1'b0, PMB_A_XDATA, 32'h0);
        chk("entry", r[15:0], {ppn, 4'hF, 1'b1});
        apb(1'b1, PMB_A_STATUS, 32'h1);
        xc(8'h53, 8'h00, 16'h0);
        apb(1'b0, PMB_A_STATUS, 32'h0);
        chk("range", r[PMB_ST_XERR], 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", err, 1'b1);
        // block unit alone: protected block, its read, and its neighbour
        apb(1'b1, PMB_A_CONFIG, 32'h2);
        for (i = 0; i < 4; i++) begin
            a = $random(seed);
            xc(PMB_X_PW_WR, {6'h0, a[15:14]}, 16'h1 << (4'hF - a[13:10]));
            cpu.acc(a, 1'b1, 1'b1, ok, e);
            chk("blk write", ok, 1'b0);
            cpu.acc(a, 1'b1, 1'b0, ok, e);
            chk("blk read", ok, 1'b1);
            cpu.acc(a ^ 16'h0400, 1'b1, 1'b1, ok, e);
            chk("blk order", ok, 1'b1);
        end
        test_done;
    end
endmodule // tb
